/* File: src/lo_ctrl_pkg.sv */
// ****************************************************************
// Shared constants of the oscillator control block
// ****************************************************************
package lo_ctrl_pkg;

  // ****************************************************************
  // Oscillator bank and converter
  // ****************************************************************
  localparam int unsigned OSC_COUNT  = 24;
  localparam int unsigned IDX_W      = 5;
  localparam int unsigned CODE_W     = 3;
  localparam logic [4:0]  OSC_LAST   = 5'h17;
  localparam logic [4:0]  TRIES_LAST = 5'h17;
  localparam logic [2:0]  CODE_SL_LO = 3'h2;
  localparam logic [2:0]  CODE_SL_HI = 3'h5;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned SYS_CLK_MHZ    = 40;
  localparam int unsigned SETTLE_TIME_NS = 10000;
  localparam int unsigned SETTLE_CYCLES  =
    (SETTLE_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int unsigned SETTLE_W       = 9;
  localparam logic [8:0]  SETTLE_LOAD    = 9'(SETTLE_CYCLES - 1);

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_OSC_CTRL = 8'h00;
  localparam logic [7:0] OFS_CONTROL  = 8'h04;
  localparam logic [7:0] OFS_FILTER   = 8'h08;
  localparam logic [7:0] OFS_INT_DIV  = 8'h0C;
  localparam logic [7:0] OFS_FRAC_HI  = 8'h10;
  localparam logic [7:0] OFS_FRAC_LO  = 8'h14;
  localparam logic [7:0] OFS_STATUS1  = 8'h18;
  localparam logic [7:0] OFS_STATUS2  = 8'h1C;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned OC_SEL_LSB = 0;
  localparam int unsigned OC_AUTO    = 5;
  localparam int unsigned OC_CONV_EN = 6;
  localparam int unsigned OC_LATCH   = 7;
  localparam int unsigned CT_LOW_POWER_STANDBY    = 0;
  localparam int unsigned ST1_DONE   = 0;
  localparam int unsigned ST1_OK     = 1;
  localparam int unsigned ST2_CODE   = 0;
  localparam int unsigned ST2_IDX    = 3;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_OSC_CTRL = 8'h00;
  localparam logic [7:0] RST_FILTER   = 8'h80;
  localparam logic [7:0] RST_INT_DIV  = 8'h00;
  localparam logic [7:0] RST_FRAC     = 8'h00;

  function automatic logic in_search_window(input logic [2:0] code);
    in_search_window = (code == CODE_SL_LO) || (code == CODE_SL_HI);
  endfunction : in_search_window

endpackage : lo_ctrl_pkg

/* File: src/search_if.sv */
`timescale 1ns/1ps
// ****************************************************************
// Link between register front end and search engine
// ****************************************************************
interface search_if;
  logic       start;
  logic [4:0] start_index;
  logic [2:0] tune_code;
  logic       run;
  logic       busy;
  logic       done;
  logic       success;
  logic [4:0] index;

  modport ctrl (
    output start, start_index, tune_code, run,
    input  busy, done, success, index
  );
  modport engine (
    input  start, start_index, tune_code, run,
    output busy, done, success, index
  );
endinterface : search_if

/* File: src/osc_search.sv */
`timescale 1ns/1ps
// ****************************************************************
// Automatic oscillator search engine
// ****************************************************************
module osc_search (
  // Clock, reset and enable
  input  wire logic   sys_clk,
  input  wire logic   nrst,
  input  wire logic   ce,
  // Front end
  search_if.engine    sif
);

  typedef enum logic [2:0] {
    S_IDLE   = 3'b001,
    S_SETTLE = 3'b010,
    S_CHECK  = 3'b100
  } search_state_t;

  search_state_t state_reg;
  logic [8:0]    settle_reg;
  logic [4:0]    tries_reg;
  logic [4:0]    index_reg;
  logic          done_reg;
  logic          ok_reg;

  wire       step   = ce && sif.run;
  wire       hit    = lo_ctrl_pkg::in_search_window(sif.tune_code);
  wire [4:0] first  = (sif.start_index > lo_ctrl_pkg::OSC_LAST) ?
                      5'h00 : sif.start_index;
  wire [4:0] next_i = (index_reg == lo_ctrl_pkg::OSC_LAST) ?
                      5'h00 : index_reg + 5'h01;

  assign sif.busy    = (state_reg != S_IDLE);
  assign sif.done    = done_reg;
  assign sif.success = ok_reg;
  assign sif.index   = index_reg;

  // Start wins over anything in flight, so a rewrite restarts cleanly
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_reg  <= S_IDLE;
      settle_reg <= 9'h000;
      tries_reg  <= 5'h00;
      index_reg  <= 5'h00;
      done_reg   <= 1'b0;
      ok_reg     <= 1'b0;
    end else if (ce && sif.start) begin
      state_reg  <= S_SETTLE;
      index_reg  <= first;
      tries_reg  <= 5'h00;
      settle_reg <= lo_ctrl_pkg::SETTLE_LOAD;
      done_reg   <= 1'b0;
      ok_reg     <= 1'b0;
    end else if (step) begin
      unique case (state_reg)
        S_IDLE: begin
        end
        S_SETTLE: begin
          settle_reg <= settle_reg - 9'h001;
          if (settle_reg == 9'h000) begin
            state_reg <= S_CHECK;
          end
        end
        S_CHECK: begin
          if (hit) begin
            state_reg <= S_IDLE;
            done_reg  <= 1'b1;
            ok_reg    <= 1'b1;
          end else if (tries_reg == lo_ctrl_pkg::TRIES_LAST) begin
            state_reg <= S_IDLE;
            done_reg  <= 1'b1;
            ok_reg    <= 1'b0;
          end else begin
            state_reg  <= S_SETTLE;
            index_reg  <= next_i;
            tries_reg  <= tries_reg + 5'h01;
            settle_reg <= lo_ctrl_pkg::SETTLE_LOAD;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  a_start_index: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ce && sif.start && sif.start_index <= lo_ctrl_pkg::OSC_LAST)
    |=> index_reg == $past(sif.start_index))
    else $error("search did not start at the manual index");

  a_busy_done: assert property (@(posedge sys_clk) disable iff (!nrst)
    sif.busy |-> !done_reg)
    else $error("done flag set while search runs");

  a_ok_window: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(ok_reg) |-> lo_ctrl_pkg::in_search_window($past(sif.tune_code)))
    else $error("accepted oscillator outside search window");

  a_fail_tries: assert property (@(posedge sys_clk) disable iff (!nrst)
    ($rose(done_reg) && !ok_reg)
    |-> $past(tries_reg) == lo_ctrl_pkg::TRIES_LAST)
    else $error("search failed before trying every oscillator");

endmodule : osc_search

/* File: src/lo_synth_ctrl.sv */
`timescale 1ns/1ps
module lo_synth_ctrl (
  // Clock, reset, enable
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Tune voltage converter code
  input  wire logic [2:0]  osc_tune_voltage,
  // Synthesizer and analog controls
  output logic [4:0]       osc_active_index,
  output logic [7:0]       filter_corner_code,
  output logic [7:0]       int_div_word,
  output logic [15:0]      frac_div_word,
  output logic             low_power_standby,
  output logic             signal_path_enable,
  output logic             converter_power_enable
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [4:0]  osc_select_index;
  logic        auto_osc_select_enable;
  logic        tune_converter_enable;
  logic        standby_reg;
  logic [7:0]  filter_reg;
  logic [7:0]  int_div_reg;
  logic [7:0]  frac_hi_reg;
  logic [7:0]  frac_lo_reg;
  logic [2:0]  latched_code_reg;
  logic [4:0]  active_index_reg;
  logic        wr_pend_reg;
  logic        rd_pend_reg;
  logic [7:0]  addr_reg;
  logic        ready_reg;
  logic [31:0] rdata_reg;

  search_if sif ();

  osc_search u_search (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .ce      (ce),
    .sif     (sif)
  );

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  // hsize is not checked: only whole-word single transfers are used
  wire take      = ce && hsel && htrans[1] && hready;
  wire wr_now    = ce && wr_pend_reg;
  wire wr_osc    = wr_now && (addr_reg == lo_ctrl_pkg::OFS_OSC_CTRL);
  wire wr_ctl    = wr_now && (addr_reg == lo_ctrl_pkg::OFS_CONTROL);
  wire wr_filt   = wr_now && (addr_reg == lo_ctrl_pkg::OFS_FILTER);
  wire wr_int    = wr_now && (addr_reg == lo_ctrl_pkg::OFS_INT_DIV);
  wire wr_fhi    = wr_now && (addr_reg == lo_ctrl_pkg::OFS_FRAC_HI);
  wire wr_flo    = wr_now && (addr_reg == lo_ctrl_pkg::OFS_FRAC_LO);
  wire latch_req = wr_osc && hwdata[lo_ctrl_pkg::OC_LATCH];
  // Converter must already be on from an earlier write
  wire capture   = latch_req && tune_converter_enable
                   && !standby_reg;

  // ****************************************************************
  // Search hookup
  // ****************************************************************
  assign sif.start       = wr_flo && auto_osc_select_enable
                           && !standby_reg;
  assign sif.start_index = osc_select_index;
  assign sif.tune_code   = osc_tune_voltage;
  assign sif.run         = !standby_reg;

  // ****************************************************************
  // Read mux
  // ****************************************************************
  wire [7:0] osc_ctrl_rd = {1'b0, tune_converter_enable,
                            auto_osc_select_enable, osc_select_index};
  wire [7:0] status1_rd  = {6'h00, sif.success, sif.done};
  wire [7:0] status2_rd  = {active_index_reg, latched_code_reg};
  wire [7:0] rd_byte =
    (addr_reg == lo_ctrl_pkg::OFS_OSC_CTRL) ? osc_ctrl_rd :
    (addr_reg == lo_ctrl_pkg::OFS_CONTROL)  ? {7'h00, standby_reg} :
    (addr_reg == lo_ctrl_pkg::OFS_FILTER)   ? filter_reg :
    (addr_reg == lo_ctrl_pkg::OFS_INT_DIV)  ? int_div_reg :
    (addr_reg == lo_ctrl_pkg::OFS_FRAC_HI)  ? frac_hi_reg :
    (addr_reg == lo_ctrl_pkg::OFS_FRAC_LO)  ? frac_lo_reg :
    (addr_reg == lo_ctrl_pkg::OFS_STATUS1)  ? status1_rd :
    (addr_reg == lo_ctrl_pkg::OFS_STATUS2)  ? status2_rd : 8'h00;
  wire [4:0] active_next = auto_osc_select_enable ?
                           sif.index : osc_select_index;

  // ****************************************************************
  // Bus phase tracking
  // ****************************************************************
  // Reads take one wait state so a write just before is seen
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
      ready_reg   <= 1'b1;
      rdata_reg   <= 32'h0000_0000;
    end else if (ce) begin
      wr_pend_reg <= take && hwrite;
      rd_pend_reg <= take && !hwrite;
      if (take) begin
        addr_reg <= {haddr[7:2], 2'b00};
      end
      ready_reg <= !(take && !hwrite);
      if (rd_pend_reg) begin
        rdata_reg <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  // Nothing here depends on standby, so settings are retained
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      osc_select_index       <= lo_ctrl_pkg::RST_OSC_CTRL[4:0];
      auto_osc_select_enable <= 1'b0;
      tune_converter_enable  <= 1'b0;
      standby_reg            <= 1'b0;
      filter_reg             <= lo_ctrl_pkg::RST_FILTER;
      int_div_reg            <= lo_ctrl_pkg::RST_INT_DIV;
      frac_hi_reg            <= lo_ctrl_pkg::RST_FRAC;
      frac_lo_reg            <= lo_ctrl_pkg::RST_FRAC;
    end else begin
      if (wr_osc) begin
        osc_select_index       <= hwdata[4:0];
        auto_osc_select_enable <= hwdata[lo_ctrl_pkg::OC_AUTO];
        tune_converter_enable  <= hwdata[lo_ctrl_pkg::OC_CONV_EN];
      end
      if (wr_ctl) begin
        standby_reg <= hwdata[lo_ctrl_pkg::CT_LOW_POWER_STANDBY];
      end
      if (wr_filt) begin
        filter_reg <= hwdata[7:0];
      end
      if (wr_int) begin
        int_div_reg <= hwdata[7:0];
      end
      if (wr_fhi) begin
        frac_hi_reg <= hwdata[7:0];
      end
      if (wr_flo) begin
        frac_lo_reg <= hwdata[7:0];
      end
    end
  end

  // ****************************************************************
  // Converter latch and outputs
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      latched_code_reg       <= 3'h0;
      active_index_reg       <= 5'h00;
      osc_active_index       <= 5'h00;
      filter_corner_code     <= lo_ctrl_pkg::RST_FILTER;
      int_div_word           <= lo_ctrl_pkg::RST_INT_DIV;
      frac_div_word          <= {lo_ctrl_pkg::RST_FRAC, lo_ctrl_pkg::RST_FRAC};
      low_power_standby      <= 1'b0;
      signal_path_enable     <= 1'b1;
      converter_power_enable <= 1'b0;
    end else if (ce) begin
      if (capture) begin
        latched_code_reg <= osc_tune_voltage;
      end
      active_index_reg       <= active_next;
      osc_active_index       <= active_next;
      filter_corner_code     <= filter_reg;
      int_div_word           <= int_div_reg;
      frac_div_word          <= {frac_hi_reg, frac_lo_reg};
      low_power_standby      <= standby_reg;
      signal_path_enable     <= !standby_reg;
      converter_power_enable <= tune_converter_enable && !standby_reg;
    end
  end

  assign hreadyout = ready_reg;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_search_start: assert property (@(posedge sys_clk) disable iff (!nrst)
    (wr_flo && auto_osc_select_enable && !standby_reg)
    |=> sif.busy && !sif.done)
    else $error("low word write did not start search");

  a_manual_no_search: assert property (@(posedge sys_clk) disable iff (!nrst)
    (wr_flo && !auto_osc_select_enable && !sif.busy)
    |=> $stable(sif.done) && $stable(sif.success) && !sif.busy)
    else $error("search flags moved with auto select off");

  a_manual_index: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ce && !auto_osc_select_enable)
    |=> osc_active_index == $past(osc_select_index))
    else $error("manual oscillator not in use");

  a_auto_index: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ce && auto_osc_select_enable && sif.done && sif.success)
    |=> osc_active_index == $past(sif.index))
    else $error("chosen oscillator not in use");

  a_latch_code: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ce && capture) |=> latched_code_reg == $past(osc_tune_voltage))
    else $error("converter code not captured");

  a_latch_needs_en: assert property (@(posedge sys_clk) disable iff (!nrst)
    (latch_req && !tune_converter_enable) |=> $stable(latched_code_reg))
    else $error("capture without converter enabled");

  a_status2_read: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ce && rd_pend_reg && addr_reg == lo_ctrl_pkg::OFS_STATUS2)
    |=> hreadyout && hrdata[7:0] == $past(status2_rd))
    else $error("status byte two read wrong");

  a_standby_path: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ce && wr_ctl && hwdata[lo_ctrl_pkg::CT_LOW_POWER_STANDBY]) ##1 ce
    |=> low_power_standby && !signal_path_enable && !converter_power_enable)
    else $error("standby did not shut the signal path");

  a_standby_keep: assert property (@(posedge sys_clk) disable iff (!nrst)
    (standby_reg && !wr_filt && !wr_osc) |=> $stable(filter_reg)
    && $stable(osc_select_index))
    else $error("settings lost in standby");

  a_filter_write: assert property (@(posedge sys_clk) disable iff (!nrst)
    (wr_filt && ce) ##1 ce |=> filter_corner_code == $past(hwdata[7:0], 2))
    else $error("filter code not applied");

endmodule : lo_synth_ctrl

/* File: sim/lo_synth_ctrl_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    err_total++; \
    $display("FAIL %s expected %0h seen %0h", nm, exp, got); \
  end \
end

module lo_synth_ctrl_tb;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        sys_clk;
  logic        nrst;
  logic        ce;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [2:0]  osc_tune_voltage;
  logic [4:0]  osc_active_index;
  logic [7:0]  filter_corner_code;
  logic [7:0]  int_div_word;
  logic [15:0] frac_div_word;
  logic        low_power_standby;
  logic        signal_path_enable;
  logic        converter_power_enable;
  logic [31:0] rd;
  int          err_total;
  int          total_checks;
  int          cyc;

  lo_synth_ctrl uut (
    .sys_clk                (sys_clk),
    .nrst                   (nrst),
    .ce                     (ce),
    .hsel                   (hsel),
    .haddr                  (haddr),
    .htrans                 (htrans),
    .hwrite                 (hwrite),
    .hsize                  (hsize),
    .hwdata                 (hwdata),
    .hready                 (hreadyout),
    .hreadyout              (hreadyout),
    .hresp                  (hresp),
    .hrdata                 (hrdata),
    .osc_tune_voltage       (osc_tune_voltage),
    .osc_active_index       (osc_active_index),
    .filter_corner_code     (filter_corner_code),
    .int_div_word           (int_div_word),
    .frac_div_word          (frac_div_word),
    .low_power_standby      (low_power_standby),
    .signal_path_enable     (signal_path_enable),
    .converter_power_enable (converter_power_enable)
  );

  always #12.5 sys_clk = ~sys_clk;

  // ****************************************************************
  // Closing and timeout
  // ****************************************************************
  task automatic results;
    $display("Checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  // Two full failed searches take about 20000 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      results();
    end
  end

  // ****************************************************************
  // Bus tasks, entered and left just after a rising edge
  // ****************************************************************
  task automatic bus(input logic wr, input logic [7:0] ofs,
                     input logic [31:0] wd, output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h000000, ofs};
    hwrite <= wr;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, ofs, {24'h000000, d}, q);
  endtask : wr

  task automatic rdr(input logic [7:0] ofs);
    bus(1'b0, ofs, 32'h00000000, rd);
  endtask : rdr

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  // Polls status one; a failed search runs all 24 candidates
  task automatic wait_done;
    int i;
    rdr(lo_ctrl_pkg::OFS_STATUS1);
    for (i = 0; i < 6000 && rd[0] !== 1'b1; i++) begin
      rdr(lo_ctrl_pkg::OFS_STATUS1);
    end
  endtask : wait_done

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    osc_tune_voltage = 3'h0;
    err_total = 0;
    total_checks = 0;
    cyc = 0;
    tick(12);
    nrst <= 1'b1;
    tick(1);

    rdr(lo_ctrl_pkg::OFS_FILTER);
    `CHK("filter reset", 32'h00000080, rd)
    `CHK("path enable", 1'b1, signal_path_enable)
    `CHK("okay resp", 1'b0, hresp)
    rdr(8'h40);
    `CHK("unmapped read", 32'h00000000, rd)
    $display("Test reset done");

    wr(lo_ctrl_pkg::OFS_OSC_CTRL, 8'h15);
    wr(lo_ctrl_pkg::OFS_FILTER, 8'h3C);
    wr(lo_ctrl_pkg::OFS_INT_DIV, 8'h5A);
    wr(lo_ctrl_pkg::OFS_FRAC_HI, 8'h12);
    wr(lo_ctrl_pkg::OFS_FRAC_LO, 8'h34);
    wr(lo_ctrl_pkg::OFS_STATUS1, 8'h03);
    tick(2);
    `CHK("manual index", 5'h15, osc_active_index)
    `CHK("filter code", 8'h3C, filter_corner_code)
    `CHK("int div", 8'h5A, int_div_word)
    `CHK("frac div", 16'h1234, frac_div_word)
    rdr(lo_ctrl_pkg::OFS_STATUS1);
    `CHK("no search manual", 32'h00000000, rd)
    rdr(lo_ctrl_pkg::OFS_STATUS2);
    `CHK("status2 manual", 32'h000000A8, rd)
    $display("Test manual done");

    wr(lo_ctrl_pkg::OFS_OSC_CTRL, 8'h40);
    for (int c = 0; c < 8; c++) begin
      osc_tune_voltage <= 3'(c);
      tick(2);
      wr(lo_ctrl_pkg::OFS_OSC_CTRL, 8'hC0);
      rdr(lo_ctrl_pkg::OFS_STATUS2);
      `CHK("latched code", {29'h0, 3'(c)}, rd)
    end
    `CHK("conv power", 1'b1, converter_power_enable)
    $display("Test converter done");

    osc_tune_voltage <= 3'h5;
    wr(lo_ctrl_pkg::OFS_OSC_CTRL, 8'h37);
    wr(lo_ctrl_pkg::OFS_FRAC_LO, 8'h34);
    rdr(lo_ctrl_pkg::OFS_STATUS1);
    `CHK("done cleared", 32'h00000000, rd)
    wait_done();
    `CHK("search ok", 32'h00000003, rd)
    rdr(lo_ctrl_pkg::OFS_STATUS2);
    `CHK("chosen index", 5'h17, rd[7:3])
    `CHK("active index", 5'h17, osc_active_index)
    $display("Test search ok done");

    osc_tune_voltage <= 3'h6;
    wr(lo_ctrl_pkg::OFS_FRAC_LO, 8'h34);
    wait_done();
    `CHK("search fail", 32'h00000001, rd)
    osc_tune_voltage <= 3'h2;
    wr(lo_ctrl_pkg::OFS_FRAC_LO, 8'h34);
    wait_done();
    `CHK("restart ok", 32'h00000003, rd)
    rdr(lo_ctrl_pkg::OFS_STATUS2);
    `CHK("restart index", 5'h17, rd[7:3])
    // Converter left on so that standby visibly turns it off
    wr(lo_ctrl_pkg::OFS_OSC_CTRL, 8'h57);
    osc_tune_voltage <= 3'h0;
    wr(lo_ctrl_pkg::OFS_FRAC_LO, 8'h34);
    rdr(lo_ctrl_pkg::OFS_STATUS1);
    `CHK("flags kept", 32'h00000003, rd)
    $display("Test search fail done");

    `CHK("conv on", 1'b1, converter_power_enable)
    wr(lo_ctrl_pkg::OFS_CONTROL, 8'h01);
    tick(2);
    `CHK("standby out", 1'b1, low_power_standby)
    `CHK("path off", 1'b0, signal_path_enable)
    `CHK("conv off", 1'b0, converter_power_enable)
    rdr(lo_ctrl_pkg::OFS_FILTER);
    `CHK("filter kept", 32'h0000003C, rd)
    wr(lo_ctrl_pkg::OFS_CONTROL, 8'h00);
    tick(2);
    `CHK("path back", 1'b1, signal_path_enable)
    `CHK("filter back", 8'h3C, filter_corner_code)
    `CHK("frac back", 16'h1234, frac_div_word)
    rdr(lo_ctrl_pkg::OFS_OSC_CTRL);
    `CHK("osc ctrl kept", 32'h00000057, rd)
    `CHK("conv back", 1'b1, converter_power_enable)
    $display("Test standby done");
    results();
  end
endmodule : lo_synth_ctrl_tb
